// ===== include/fmac_consts.svh
// Constants for the fault mask and converter control register bank.
// Functional notes
// - Bit7 mask blocks input undervoltage interrupt pulse
// - Bit6 mask blocks input overvoltage interrupt pulse
// - Bit5 mask blocks output overcurrent interrupt pulse
// - Bit4 mask blocks output overvoltage interrupt pulse
// - Bit3 mask blocks thermal shutdown interrupt pulse
// - Bit1 masks driver supply fault; bits2,0 zero
// - Fault mask at 0x2A, resets 0x00
// - Bit7 enables converter; forced by temp compensation
// - Bit6 one-shot when set, resets to one
// - Bits5:4 resolution select, 11 reserved, reset 10
// - Bit3 selects running average of conversions
// - Bit2 seeds average from fresh conversion
// - Control at 0x2B, resets 0x60, bits1:0 zero
// - Fault flags read-only, cleared on host read
// - Conversion-done pulse only in one-shot mode
`ifndef FMAC_CONSTS_SVH
`define FMAC_CONSTS_SVH
`define FMAC_ADDR_FLAG 8'h27
`define FMAC_ADDR_MASK1 8'h28
`define FMAC_ADDR_FMASK 8'h2A
`define FMAC_ADDR_CTRL 8'h2B
`define FMAC_FMASK_RST 8'h00
`define FMAC_CTRL_RST 8'h60
`define FMAC_FMASK_WMASK 8'hFA
`define FMAC_CTRL_WMASK 8'hFC
`define FMAC_FLAG_WMASK 8'hFA
`define FMAC_MASK1_DONE_BIT 7
`define FMAC_CTRL_EN_BIT 7
`define FMAC_CTRL_ONESHOT_BIT 6
`define FMAC_RES_RESERVED 2'h3
`define FMAC_RES_DEFAULT 2'h2
`define FMAC_PULSE_NS 1000
`define FMAC_PULSE_CYC ((`FMAC_PULSE_NS + 24) / 25)
`endif

// ===== include/fmac_pkg.sv
// Types shared by the fault mask and converter control register bank.
package fmac_pkg;
  typedef struct packed {
    logic input_undervoltage_irq_mask;
    logic input_overvoltage_irq_mask;
    logic output_overcurrent_irq_mask;
    logic output_overvoltage_irq_mask;
    logic thermal_shutdown_irq_mask;
    logic rsvd2;
    logic driver_supply_fault_irq_mask;
    logic rsvd0;
  } fmac_fmask_t;
  typedef struct packed {
    logic adc_enable;
    logic one_shot;
    logic [1:0] resolution_select;
    logic running_average_enable;
    logic average_seed_select;
    logic [1:0] rsvd;
  } fmac_ctrl_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fmac_req_t;
  typedef enum logic [1:0] {
    FMAC_IDLE = 2'b00,
    FMAC_PULSE = 2'b01
  } fmac_state_t;
endpackage

// ===== design/fmac_pulse.sv
// Stretches an interrupt request into a fixed-length low pulse.
`timescale 1ns/100ps
`default_nettype none
module fmac_pulse #(
  parameter int unsigned LEN = 40
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic trig,
  output logic int_n
);
  fmac_pkg::fmac_state_t state_ff, nxt_state;
  logic [15:0] cnt_ff, nxt_cnt;
  logic int_n_ff, nxt_int_n;

  // --------------------------------------------------------------
  // Pulse sequencer
  // --------------------------------------------------------------
  // Triggers during a pulse are merged into it; the host reads flags.
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_int_n = int_n_ff;
    unique case (state_ff)
      fmac_pkg::FMAC_IDLE: begin
        if (trig) begin
          nxt_state = fmac_pkg::FMAC_PULSE;
          nxt_cnt = 16'(LEN - 1);
          nxt_int_n = 1'b0;
        end
      end
      fmac_pkg::FMAC_PULSE: begin
        if (cnt_ff == 16'h0000) begin
          nxt_state = fmac_pkg::FMAC_IDLE;
          nxt_int_n = 1'b1;
        end else begin
          nxt_cnt = cnt_ff - 16'h0001;
        end
      end
      default: begin
        nxt_state = fmac_pkg::FMAC_IDLE;
        nxt_int_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_ff <= fmac_pkg::FMAC_IDLE;
      cnt_ff <= 16'h0000;
      int_n_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      int_n_ff <= nxt_int_n;
    end
  end

  assign int_n = int_n_ff;
endmodule
`default_nettype wire

// ===== design/fmac_regs.sv
// Fault mask and converter control registers with flag and pulse logic.
`timescale 1ns/100ps
`default_nettype none
`include "fmac_consts.svh"
module fmac_regs (
  input wire logic clk,
  input wire logic nrst,
  input wire fmac_pkg::fmac_req_t req,
  output logic [7:0] rdata,
  input wire logic reg_reset,
  input wire logic watchdog_expired,
  input wire logic temp_compensated_regulation_enable,
  input wire logic [7:0] fault_event,
  input wire logic conversion_done,
  output fmac_pkg::fmac_fmask_t fault_mask,
  output fmac_pkg::fmac_ctrl_t converter_ctrl,
  output logic adc_active,
  output logic [7:0] fault_flags,
  output logic int_n
);
  logic [7:0] fmask_ff, nxt_fmask;
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [7:0] flag_ff, nxt_flag;
  logic done_mask_ff, nxt_done_mask;
  logic [7:0] rdata_ff, nxt_rdata;
  logic [7:0] unmasked;
  logic done_pulse;
  logic trig;

  // --------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------
  // Register reset returns the fault mask, control and done mask to their defaults.
  always_comb begin
    nxt_fmask = fmask_ff;
    nxt_ctrl = ctrl_ff;
    nxt_done_mask = done_mask_ff;
    if (req.wr && req.addr == `FMAC_ADDR_FMASK) begin
      nxt_fmask = req.wdata & `FMAC_FMASK_WMASK;
    end
    if (req.wr && req.addr == `FMAC_ADDR_CTRL) begin
      nxt_ctrl = req.wdata & `FMAC_CTRL_WMASK;
    end
    if (req.wr && req.addr == `FMAC_ADDR_MASK1) begin
      nxt_done_mask = req.wdata[`FMAC_MASK1_DONE_BIT];
    end
    if (watchdog_expired) begin
      nxt_ctrl[`FMAC_CTRL_EN_BIT] = 1'b0;
    end
    if (reg_reset) begin
      nxt_fmask = `FMAC_FMASK_RST;
      nxt_ctrl = `FMAC_CTRL_RST;
      nxt_done_mask = 1'b0;
    end
  end

  // --------------------------------------------------------------
  // Fault flags
  // --------------------------------------------------------------
  // A new event in the read cycle wins over the clear, so none is lost.
  always_comb begin
    nxt_flag = flag_ff;
    if (req.rd && req.addr == `FMAC_ADDR_FLAG) begin
      nxt_flag = 8'h00;
    end
    nxt_flag = nxt_flag | (fault_event & `FMAC_FLAG_WMASK);
  end

  // --------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------
  always_comb begin
    nxt_rdata = 8'h00;
    if (req.rd) begin
      unique case (req.addr)
        `FMAC_ADDR_FMASK: nxt_rdata = fmask_ff;
        `FMAC_ADDR_CTRL: nxt_rdata = ctrl_ff;
        `FMAC_ADDR_FLAG: nxt_rdata = flag_ff;
        `FMAC_ADDR_MASK1: nxt_rdata = {done_mask_ff, 7'h00};
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      fmask_ff <= `FMAC_FMASK_RST;
      ctrl_ff <= `FMAC_CTRL_RST;
      flag_ff <= 8'h00;
      done_mask_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else begin
      fmask_ff <= nxt_fmask;
      ctrl_ff <= nxt_ctrl;
      flag_ff <= nxt_flag;
      done_mask_ff <= nxt_done_mask;
      rdata_ff <= nxt_rdata;
    end
  end

  // --------------------------------------------------------------
  // Interrupt gating
  // --------------------------------------------------------------
  // Masks gate only the pulse; flags and responses are untouched.
  assign unmasked = fault_event & `FMAC_FLAG_WMASK & ~fmask_ff;
  // Done pulse allowed only while one-shot is selected.
  assign done_pulse = conversion_done & ctrl_ff[`FMAC_CTRL_ONESHOT_BIT] & ~done_mask_ff;
  assign trig = (|unmasked) | done_pulse;

  fmac_pulse #(
    .LEN(`FMAC_PULSE_CYC)
  ) u_pulse (
    .clk(clk),
    .nrst(nrst),
    .trig(trig),
    .int_n(int_n)
  );

  // Converter runs when enabled or when temperature compensation needs it.
  assign adc_active = ctrl_ff[`FMAC_CTRL_EN_BIT] | temp_compensated_regulation_enable;
  assign fault_mask = fmac_pkg::fmac_fmask_t'(fmask_ff);
  assign converter_ctrl = fmac_pkg::fmac_ctrl_t'(ctrl_ff);
  assign fault_flags = flag_ff;
  assign rdata = rdata_ff;
endmodule
`default_nettype wire

// ===== dv/fmac_host.sv
// Host model that issues byte register cycles to the bank.
`timescale 1ns/100ps
`default_nettype none
module fmac_host (
  input wire logic clk,
  output var fmac_pkg::fmac_req_t req,
  input wire logic [7:0] rdata
);
  // One strobe per call; released data is inverted so it never looks held.
  initial req = '0;
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{1'h1, 1'h0, a, d};
    @(posedge clk) req <= '{1'h0, 1'h0, a, ~d};
  endtask
  // Read data is registered, so it is taken one cycle after the strobe.
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) req <= '{1'h0, 1'h1, a, 8'h00};
    @(posedge clk) req <= '0;
    #1 d = rdata;
  endtask
endmodule
`default_nettype wire

// ===== dv/fmac_regs_properties.sv
// Concurrent checks on the register bank ports.
`timescale 1ns/100ps
`default_nettype none
module fmac_regs_properties (
  input wire logic clk,
  input wire logic nrst,
  input wire fmac_pkg::fmac_req_t req,
  input wire logic [7:0] rdata,
  input wire logic reg_reset,
  input wire logic watchdog_expired,
  input wire logic temp_compensated_regulation_enable,
  input wire logic [7:0] fault_event,
  input wire logic conversion_done,
  input wire fmac_pkg::fmac_fmask_t fault_mask,
  input wire fmac_pkg::fmac_ctrl_t converter_ctrl,
  input wire logic adc_active,
  input wire logic [7:0] fault_flags,
  input wire logic int_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Open events are fault pulses whose mask bit is clear.
  wire logic open_ev = |(fault_event & ~fault_mask & 8'hFA);
  sequence pulse_end_s;
    ##39 !int_n ##1 int_n;
  endsequence
  a_mask_write: assert property (req.wr && req.addr == 8'h2A && !reg_reset
    |=> fault_mask == ($past(req.wdata) & 8'hFA))
    else $error("mask write wrong");
  a_ctrl_write: assert property (req.wr && req.addr == 8'h2B && !reg_reset
    && !watchdog_expired |=> converter_ctrl == ($past(req.wdata) & 8'hFC))
    else $error("control write wrong");
  a_reg_default: assert property (reg_reset |=> fault_mask == 8'h00 &&
    converter_ctrl == 8'h60) else $error("register reset wrong");
  a_wdog_clear: assert property (watchdog_expired && !req.wr |=>
    !converter_ctrl.adc_enable) else $error("enable not cleared");
  a_adc_forced: assert property (adc_active == (converter_ctrl.adc_enable
    | temp_compensated_regulation_enable)) else $error("adc active");
  a_event_pulse: assert property (int_n && open_ev |=> !int_n)
    else $error("open event gave no pulse");
  a_flag_sets: assert property (fault_event[7] |=> fault_flags[7])
    else $error("flag not set");
  a_done_blocked: assert property (int_n && conversion_done && !open_ev &&
    !converter_ctrl.one_shot |=> int_n)
    else $error("continuous mode pulse");
  a_pulse_length: assert property ($fell(int_n) |-> pulse_end_s)
    else $error("pulse length wrong");
  a_flags_all_set: assert property ((|fault_event) |=>
    (fault_flags & $past(fault_event) & 8'hFA) ==
    ($past(fault_event) & 8'hFA)) else $error("flag bit not set");
  a_flag_read_clear: assert property (req.rd && req.addr == 8'h27 &&
    !(|fault_event) |=> fault_flags == 8'h00)
    else $error("flags not cleared by read");
  a_reserved_zero: assert property ((fault_mask & 8'h05) == 8'h00 &&
    converter_ctrl.rsvd == 2'h0) else $error("reserved bit set");
endmodule
bind fmac_regs fmac_regs_properties chk_u (.clk(clk), .nrst(nrst),
  .req(req), .rdata(rdata), .reg_reset(reg_reset),
  .watchdog_expired(watchdog_expired),
  .temp_compensated_regulation_enable(temp_compensated_regulation_enable),
  .fault_event(fault_event), .conversion_done(conversion_done),
  .fault_mask(fault_mask), .converter_ctrl(converter_ctrl),
  .adc_active(adc_active), .fault_flags(fault_flags), .int_n(int_n));
`default_nettype wire

// ===== dv/fmac_regs_test.sv
// Self-checking bench for the register bank.
`timescale 1ns/100ps
`default_nettype none
module fmac_regs_test;
  logic clk = 1'h0, nrst = 1'h0, rrst = 1'h0, wdog = 1'h0, temp = 1'h0;
  logic done = 1'h0, adc, int_n;
  logic [7:0] fev = 8'h00, rdata, d;
  logic [7:0] fmask_o, ctrl_o, flags_o;
  logic [7:0] bits [6] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h02};
  fmac_pkg::fmac_req_t req;
  int n_errors = 0, tests_run = 0, cyc = 0;
  fmac_regs dut_u (.clk(clk), .nrst(nrst), .req(req), .rdata(rdata),
    .reg_reset(rrst), .watchdog_expired(wdog),
    .temp_compensated_regulation_enable(temp), .fault_event(fev),
    .conversion_done(done), .fault_mask(fmask_o), .converter_ctrl(ctrl_o),
    .adc_active(adc), .fault_flags(flags_o), .int_n(int_n));
  fmac_host host_u (.clk(clk), .req(req), .rdata(rdata));
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    host_u.read(a, d);
    chk("rdata", e, d);
  endtask
  // Event and done strobes last one cycle; int_n is looked at just after.
  task automatic ev(logic [7:0] e, logic c);
    @(posedge clk) fev <= e;
    done <= c;
    @(posedge clk) fev <= 8'h00;
    done <= 1'h0;
    #1;
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    forever #12.5 clk = ~clk;
  end
  // The whole run needs well under a thousand cycles.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      test_done;
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'h1;
    rd(8'h2A, 8'h00);
    rd(8'h2B, 8'h60);
    host_u.write(8'h2A, 8'hFF);
    rd(8'h2A, 8'hFA);
    chk("fault_mask", 8'hFA, fmask_o);
    host_u.write(8'h2B, 8'hFF);
    rd(8'h2B, 8'hFC);
    chk("converter_ctrl", 8'hFC, ctrl_o);
    chk("adc_active", 8'h01, {7'h00, adc});
    rd(8'h30, 8'h00);
    @(posedge clk) wdog <= 1'h1;
    @(posedge clk) wdog <= 1'h0;
    rd(8'h2B, 8'h7C);
    chk("adc_active", 8'h00, {7'h00, adc});
    @(posedge clk) temp <= 1'h1;
    for (int k = 0; k < 4; k++) begin
      host_u.write(8'h2B, {2'h0, k[1:0], 4'h0});
      rd(8'h2B, {2'h0, k[1:0], 4'h0});
    end
    chk("adc_active", 8'h01, {7'h00, adc});
    @(posedge clk) rrst <= 1'h1;
    @(posedge clk) rrst <= 1'h0;
    rd(8'h2B, 8'h60);
    foreach (bits[i]) begin
      host_u.write(8'h2A, bits[i]);
      ev(bits[i], 1'h0);
      chk("int_n", 8'h01, {7'h00, int_n});
      rd(8'h27, bits[i]);
      rd(8'h27, 8'h00);
      host_u.write(8'h2A, 8'h00);
      ev(bits[i], 1'h0);
      chk("int_n", 8'h00, {7'h00, int_n});
      chk("fault_flags", bits[i], flags_o);
      rd(8'h27, bits[i]);
      repeat (45) @(posedge clk);
    end
    ev(8'h00, 1'h1);
    chk("int_n", 8'h00, {7'h00, int_n});
    repeat (45) @(posedge clk);
    host_u.write(8'h2B, 8'h00);
    ev(8'h00, 1'h1);
    chk("int_n", 8'h01, {7'h00, int_n});
    host_u.write(8'h2B, 8'h40);
    host_u.write(8'h28, 8'h80);
    rd(8'h28, 8'h80);
    ev(8'h00, 1'h1);
    chk("int_n", 8'h01, {7'h00, int_n});
    test_done;
  end
endmodule
`default_nettype wire
